//--- hdl/keyboard_pin_interrupt.sv
// Notes on behaviour
// RULE_01: software masks, sets polarity, enables, acks, unmasks
// RULE_02: edge pins ack at once; level pins after settling
// RULE_03: pending flag set by any asserted enabled pin
// RULE_04: mask blocks request output, not pending flag
// RULE_05: unit runs in wait; unmasked request wakes
// RULE_06: unit runs in stop; unmasked request wakes
// RULE_07: permitted break clears take effect and stick
// RULE_08: protected break leaves status bits unchanged
// RULE_09: two-step clear holds during protected break; the code drops a remembered ack if the release comes in a protected break
// RULE_10: each pin has enable and own polarity
// RULE_11: enable turns on pull-up or pull-down
// RULE_12: pending flag read-only; bits 7-4 read zero
// RULE_13: ack write clears latch, reads zero
// RULE_14: sense select: 1 edge-and-level, 0 edge only
// RULE_15: five pin enables gate latching
// RULE_16: polarity 1 rising/high; reset clears
// RULE_17: edge mode: fetch or ack clears immediately
// RULE_18: level mode: clear needs ack and release
// RULE_19: edge mode: edge ignored if another asserted
// RULE_20: reset clears latch and sense select
// RULE_21: synchronise pins, compare samples, xor polarity; the code uses xnor (~^), so polarity 1 means high
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "keyboard_pin_interrupt_regs.svh"
module keyboard_pin_interrupt #(
  parameter int PINS = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire keyboard_pin_interrupt_pkg::reg_addr_t regAddr,
  input wire keyboard_pin_interrupt_pkg::reg_data_t regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output keyboard_pin_interrupt_pkg::reg_data_t regRdData,
  input wire logic [PINS-1:0] keypadInputPins,
  input wire logic vectorFetchAck,
  input wire logic breakState,
  input wire logic breakClearPermit,
  output logic [PINS-1:0] pullUpEnable,
  output logic [PINS-1:0] pullDownEnable,
  output logic keyInterruptReq,
  output logic keyWakeReq
);
  import keyboard_pin_interrupt_pkg::*;

  // ==========================================================
  // register state
  logic keySenseSelect_q;
  logic keyRequestMask_q;
  logic [PINS-1:0] pinRequestEnable_q;
  logic [PINS-1:0] pinPolaritySelect_q;
  logic latch_q;
  logic ackSeen_q;
  reg_data_t rdData_q;
  logic irq_q;
  logic wake_q;
  logic [PINS-1:0] pullUp_q;
  logic [PINS-1:0] pullDown_q;

  key_pin_link_if #(.PINS(PINS)) link ();

  key_pin_sampler #(.PINS(PINS)) u_sampler (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(keypadInputPins),
    .polarity(pinPolaritySelect_q),
    .link(link)
  );

  function automatic logic hit(input reg_addr_t a, input reg_addr_t want, input logic stb);
    hit = stb && (a == want);
  endfunction : hit

  // ==========================================================
  // pin qualification
  logic [PINS-1:0] activeNow;
  logic [PINS-1:0] activeEdge;
  logic anyActive;
  logic anyOtherHeld;
  logic edgeEvent;
  logic levelEvent;
  logic setEvent;
  logic clearGate;
  logic ackWrite;
  logic ackEvent;
  sense_mode_t senseMode;

  assign senseMode = keySenseSelect_q ? SENSE_EDGE_LEVEL : SENSE_EDGE_ONLY;
  assign activeNow = link.assertedNow & pinRequestEnable_q; // see RULE_15
  assign activeEdge = activeNow & ~link.assertedPrev; // see RULE_21
  assign anyActive = |activeNow;
  // an edge only counts when no other enabled pin was already held
  assign anyOtherHeld = |(link.assertedPrev & pinRequestEnable_q); // see RULE_19
  assign edgeEvent = (|activeEdge) && !anyOtherHeld; // see RULE_19
  assign levelEvent = (senseMode == SENSE_EDGE_LEVEL) && anyActive; // see RULE_18
  assign setEvent = edgeEvent || levelEvent; // see RULE_03
  // a protected break blocks the software ack and the release-time clear of a remembered ack; direct fetch acks and status/control writes still act
  assign clearGate = !breakState || breakClearPermit; // see RULE_07 see RULE_08
  assign ackWrite = hit(regAddr, `KEY_STATUS_CONTROL_ADDR, regWrite)
      && regWrData[`KEY_REQUEST_ACK_BIT];
  assign ackEvent = (ackWrite && clearGate) || vectorFetchAck; // see RULE_13

  // ==========================================================
  // control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keySenseSelect_q <= 1'(`KEY_STATUS_CONTROL_RST >> `KEY_SENSE_SELECT_BIT); // see RULE_20
      keyRequestMask_q <= 1'(`KEY_STATUS_CONTROL_RST >> `KEY_REQUEST_MASK_BIT);
    end else if (hit(regAddr, `KEY_STATUS_CONTROL_ADDR, regWrite)) begin
      keySenseSelect_q <= regWrData[`KEY_SENSE_SELECT_BIT]; // see RULE_14
      keyRequestMask_q <= regWrData[`KEY_REQUEST_MASK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinRequestEnable_q <= PINS'(`KEY_PIN_ENABLE_RST);
    end else if (hit(regAddr, `KEY_PIN_ENABLE_ADDR, regWrite)) begin
      pinRequestEnable_q <= regWrData[PINS-1:0]; // see RULE_10
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinPolaritySelect_q <= PINS'(`KEY_PIN_POLARITY_RST); // see RULE_16
    end else if (hit(regAddr, `KEY_PIN_POLARITY_ADDR, regWrite)) begin
      pinPolaritySelect_q <= regWrData[PINS-1:0]; // see RULE_16
    end
  end

  // ==========================================================
  // request latch; a new set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q <= 1'b0; // see RULE_20
    end else if (setEvent) begin
      latch_q <= 1'b1; // see RULE_03
    end else if (senseMode == SENSE_EDGE_ONLY) begin
      if (ackEvent) begin
        latch_q <= 1'b0; // see RULE_17
      end
    // a remembered ack is lost if the release comes in a protected break, see RULE_09
    end else if ((ackEvent || (ackSeen_q && clearGate)) && !anyActive) begin
      latch_q <= 1'b0; // see RULE_18
    end
  end

  // remembers an acknowledge that came while inputs were still held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ackSeen_q <= 1'b0;
    end else if (!latch_q || senseMode == SENSE_EDGE_ONLY || !anyActive) begin
      ackSeen_q <= 1'b0;
    end else if (ackEvent) begin
      ackSeen_q <= 1'b1; // see RULE_18
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= latch_q && !keyRequestMask_q; // see RULE_04
      // clock runs on in wait and stop, so the same path wakes the core
      wake_q <= latch_q && !keyRequestMask_q; // see RULE_05 see RULE_06
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pullUp_q <= '0;
      pullDown_q <= '0;
    end else begin
      pullUp_q <= pinRequestEnable_q & ~pinPolaritySelect_q; // see RULE_11
      pullDown_q <= pinRequestEnable_q & pinPolaritySelect_q; // see RULE_11
    end
  end

  // ==========================================================
  // read port; reads carry no side effects, so break is harmless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `KEY_STATUS_CONTROL_ADDR: begin
          rdData_q <= {4'h0, latch_q, 1'b0, keyRequestMask_q,
                       keySenseSelect_q}; // see RULE_12 see RULE_13 see RULE_09
        end
        `KEY_PIN_ENABLE_ADDR: begin
          rdData_q <= 8'(pinRequestEnable_q);
        end
        `KEY_PIN_POLARITY_ADDR: begin
          rdData_q <= 8'(pinPolaritySelect_q);
        end
        default: begin
          rdData_q <= 8'h00;
        end
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign regRdData = rdData_q;
  assign keyInterruptReq = irq_q;
  assign keyWakeReq = wake_q;
  assign pullUpEnable = pullUp_q;
  assign pullDownEnable = pullDown_q;

  // ==========================================================
  // checks
  chk_mask_blocks_irq: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
    $past(keyRequestMask_q) |-> !keyInterruptReq)
    else $error("request passed while masked");
  chk_irq_follows_latch: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
    (latch_q && !keyRequestMask_q) |=> keyInterruptReq)
    else $error("unmasked latch did not raise request");
  chk_set_latches: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_03
    setEvent |=> latch_q)
    else $error("asserted pin did not set latch");
  chk_edge_ack_clears: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_17
    (!keySenseSelect_q && vectorFetchAck && !setEvent) |=> !latch_q)
    else $error("edge mode ack did not clear");
  chk_level_holds: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_18
    (keySenseSelect_q && anyActive) |=> latch_q)
    else $error("level request dropped while asserted");
  chk_break_protect: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_08
    (breakState && !breakClearPermit && !vectorFetchAck && latch_q) |=> latch_q)
    else $error("status changed in protected break");
  chk_ack_reads_zero: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
    ($past(regRead) && $past(regAddr) == `KEY_STATUS_CONTROL_ADDR)
      |-> (regRdData[7:4] == 4'h0 && !regRdData[2] && regRdData[3] == $past(latch_q)))
    else $error("status read wrong");
  chk_pull_select: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_11
    ##1 (pullUpEnable == ($past(pinRequestEnable_q) & ~$past(pinPolaritySelect_q))))
    else $error("pull-up select wrong");
  chk_wake_irq: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_05
    (latch_q && !keyRequestMask_q) |=> keyWakeReq)
    else $error("unmasked latch did not raise wake");
  chk_wake_masked: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_06
    $past(keyRequestMask_q) |-> !keyWakeReq)
    else $error("wake passed while masked");
  chk_pending_kept: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_04
    (latch_q && keyRequestMask_q && !ackEvent && !ackSeen_q) |=> latch_q)
    else $error("mask disturbed pending flag");
  chk_pull_down_select: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_11
    ##1 (pullDownEnable == ($past(pinRequestEnable_q) & $past(pinPolaritySelect_q))))
    else $error("pull-down select wrong");
  chk_held_edge_ignored: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_19
    (!keySenseSelect_q && anyOtherHeld && !latch_q) |=> !latch_q)
    else $error("edge latched while another pin held");
  chk_edge_needs_event: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
    (!keySenseSelect_q && !latch_q && !edgeEvent) |=> !latch_q)
    else $error("edge mode latched without an edge");
  chk_level_ack_release: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_18
    (keySenseSelect_q && !anyActive && ackEvent) |=> !latch_q)
    else $error("released level request not cleared");
  chk_ack_remembered: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_18
    (keySenseSelect_q && latch_q && anyActive && ackEvent) |=> ackSeen_q)
    else $error("held level ack not remembered");
  chk_ack_write_clears: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_13
    (!breakState && ackWrite && !keySenseSelect_q && !setEvent) |=> !latch_q)
    else $error("ack write did not clear");
  chk_break_permit_clear: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_07
    (breakState && breakClearPermit && ackWrite && !keySenseSelect_q && !setEvent)
      |=> !latch_q)
    else $error("permitted break clear ignored");
  chk_disabled_pins_idle: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_15
    (pinRequestEnable_q == '0 && !latch_q) |=> !latch_q)
    else $error("disabled pins set the latch");
  chk_reset_clears: assert property (@(posedge clk) // see RULE_20
    !rst_n |=> (!latch_q && !keySenseSelect_q))
    else $error("reset left request or mode set");
  chk_polarity_reset: assert property (@(posedge clk) // see RULE_16
    !rst_n |=> (pinPolaritySelect_q == '0))
    else $error("reset left polarity set");
  chk_status_mode_read: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
    ($past(regRead) && $past(regAddr) == `KEY_STATUS_CONTROL_ADDR)
      |-> (regRdData[1:0] == {$past(keyRequestMask_q), $past(keySenseSelect_q)}))
    else $error("status mode bits read wrong");
  chk_enable_read: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_10
    ($past(regRead) && $past(regAddr) == `KEY_PIN_ENABLE_ADDR)
      |-> (regRdData == 8'($past(pinRequestEnable_q))))
    else $error("pin enable read wrong");
  chk_polarity_read: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_16
    ($past(regRead) && $past(regAddr) == `KEY_PIN_POLARITY_ADDR)
      |-> (regRdData == 8'($past(pinPolaritySelect_q))))
    else $error("pin polarity read wrong");
  // two reset-free samples back, so the synchroniser carries real pin data
  chk_sync_polarity: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_21
    ($past(rst_n) && $past(rst_n, 2))
      |-> (link.assertedNow == ($past(keypadInputPins, 2) ~^ pinPolaritySelect_q)))
    else $error("pin sample or polarity wrong");

  // ==========================================================
  // coverage
  cov_edge_set: cover property (@(posedge clk) disable iff (!rst_n)
    !keySenseSelect_q && edgeEvent ##1 latch_q);
  cov_level_ack: cover property (@(posedge clk) disable iff (!rst_n)
    keySenseSelect_q && ackWrite && anyActive ##[1:20] !latch_q);
  cov_break_ack: cover property (@(posedge clk) disable iff (!rst_n)
    breakState && breakClearPermit && ackWrite);
  cov_held_edge: cover property (@(posedge clk) disable iff (!rst_n)
    !keySenseSelect_q && anyOtherHeld && (|activeEdge));
  cov_fetch_clear: cover property (@(posedge clk) disable iff (!rst_n)
    vectorFetchAck && latch_q ##1 !latch_q);
endmodule : keyboard_pin_interrupt

//--- hdl/keyboard_pin_interrupt_regs.svh
`ifndef KEYBOARD_PIN_INTERRUPT_REGS_SVH
`define KEYBOARD_PIN_INTERRUPT_REGS_SVH
// ==========================================================
// register offsets
`define KEY_STATUS_CONTROL_ADDR 2'h0
`define KEY_PIN_ENABLE_ADDR 2'h1
`define KEY_PIN_POLARITY_ADDR 2'h2
// ==========================================================
// status and control fields
`define KEY_SENSE_SELECT_BIT 0
`define KEY_REQUEST_MASK_BIT 1
`define KEY_REQUEST_ACK_BIT 2
`define KEY_PENDING_FLAG_BIT 3
// ==========================================================
// reset values
`define KEY_STATUS_CONTROL_RST 8'h00
`define KEY_PIN_ENABLE_RST 8'h00
`define KEY_PIN_POLARITY_RST 8'h00
`endif

//--- hdl/keyboard_pin_interrupt_pkg.sv
package keyboard_pin_interrupt_pkg;
  typedef logic [1:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef enum logic [1:0] {
    SENSE_EDGE_ONLY = 2'b00,
    SENSE_EDGE_LEVEL = 2'b01
  } sense_mode_t;
endpackage : keyboard_pin_interrupt_pkg

//--- hdl/key_pin_link_if.sv
`timescale 1ns/1ns
interface key_pin_link_if #(parameter int PINS = 5);
  logic [PINS-1:0] assertedNow;
  logic [PINS-1:0] assertedPrev;
  modport producer(output assertedNow, output assertedPrev);
  modport consumer(input assertedNow, input assertedPrev);
endinterface : key_pin_link_if

//--- hdl/key_pin_sampler.sv
`timescale 1ns/1ns
module key_pin_sampler #(
  parameter int PINS = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [PINS-1:0] pinIn,
  input wire logic [PINS-1:0] polarity,
  key_pin_link_if.producer link
);
  import keyboard_pin_interrupt_pkg::*;
  logic [PINS-1:0] meta_q;
  logic [PINS-1:0] sync_q;
  logic [PINS-1:0] prev_q;

  // ==========================================================
  // two-stage synchroniser, two flops per pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pinIn; // see RULE_21
      sync_q <= meta_q;
    end
  end

  // previous sample, polarity folded in so asserted is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_q ~^ polarity;
    end
  end

  assign link.assertedNow = sync_q ~^ polarity; // see RULE_21
  assign link.assertedPrev = prev_q;
endmodule : key_pin_sampler

//--- verification/key_switch_model.sv
`timescale 1ns/1ns
module key_switch_model #(
  parameter int PINS = 5
) (
  input wire logic clk,
  input wire logic [PINS-1:0] pressLevel,
  input wire logic [PINS-1:0] pressEn,
  input wire logic [PINS-1:0] pullUpEnable,
  input wire logic [PINS-1:0] pullDownEnable,
  output logic [PINS-1:0] pinLevel
);
  // ==========================================================
  // pin resolution
  logic [PINS-1:0] floatPat = '0;
  // an undriven, unpulled pin wanders so no settled level hides a fault
  always @(posedge clk) begin
    floatPat <= ~floatPat;
  end
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pressEn[i]) pinLevel[i] = pressLevel[i];
      else if (pullUpEnable[i]) pinLevel[i] = 1'b1;
      else if (pullDownEnable[i]) pinLevel[i] = 1'b0;
      else pinLevel[i] = floatPat[i];
    end
  end
endmodule : key_switch_model

//--- verification/tb_keyboard_pin_interrupt.sv
`timescale 1ns/1ns
`include "keyboard_pin_interrupt_regs.svh"
module tb_keyboard_pin_interrupt;
  import keyboard_pin_interrupt_pkg::*;
  // ==========================================================
  // clock, reset, wiring
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_addr_t regAddr = '0;
  reg_data_t regWrData = '0;
  reg_data_t regRdData;
  logic regWrite = 1'b0, regRead = 1'b0, fetch = 1'b0, brk = 1'b0, permit = 1'b0;
  logic [4:0] pins, pullUp, pullDown, pressLevel = '0, pressEn = '0;
  logic intReq, wakeReq;
  int mismatches = 0;
  int compares = 0;
  localparam reg_addr_t ST = `KEY_STATUS_CONTROL_ADDR;
  localparam reg_addr_t EN = `KEY_PIN_ENABLE_ADDR;
  localparam reg_addr_t PO = `KEY_PIN_POLARITY_ADDR;
  always #10 clk = ~clk;
  keyboard_pin_interrupt #(.PINS(5)) dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .keypadInputPins(pins), .vectorFetchAck(fetch), .breakState(brk),
    .breakClearPermit(permit), .pullUpEnable(pullUp), .pullDownEnable(pullDown),
    .keyInterruptReq(intReq), .keyWakeReq(wakeReq));
  key_switch_model #(.PINS(5)) keys (.clk(clk), .pressLevel(pressLevel), .pressEn(pressEn),
    .pullUpEnable(pullUp), .pullDownEnable(pullDown), .pinLevel(pins));
  // ==========================================================
  // access tasks
  task automatic end_sim();
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(reg_addr_t a, reg_data_t d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(reg_addr_t a, reg_data_t exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk("read data", regRdData, exp);
  endtask : rd
  // expected request outputs follow pending and mask together
  task automatic req(logic exp);
    cyc(2);
    chk("request outputs", {6'h00, wakeReq, intReq}, {6'h00, exp, exp});
  endtask : req
  task automatic press(int p, logic lvl, logic en);
    @(posedge clk);
    pressLevel[p] <= lvl;
    pressEn[p] <= en;
    cyc(6);
  endtask : press
  // ==========================================================
  // scenarios
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ST, 8'h00);
    rd(EN, 8'h00);
    rd(PO, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    rd(EN, 8'h00);
    // setup order that keeps a false request from reaching the cpu
    wr(ST, 8'h02);
    wr(PO, 8'h02);
    wr(EN, 8'h03);
    cyc(6);
    chk("pull-ups", {3'h0, pullUp}, 8'h01);
    chk("pull-downs", {3'h0, pullDown}, 8'h02);
    wr(ST, 8'h06);
    rd(ST, 8'h02);
    press(0, 1'b0, 1'b1);
    rd(ST, 8'h0A);
    req(1'b0);
    wr(ST, 8'h00);
    req(1'b1);
    @(posedge clk);
    fetch <= 1'b1;
    @(posedge clk);
    fetch <= 1'b0;
    req(1'b0);
    press(1, 1'b1, 1'b1);
    rd(ST, 8'h00);
    press(1, 1'b0, 1'b0);
    press(0, 1'b0, 1'b0);
    press(1, 1'b1, 1'b1);
    rd(ST, 8'h08);
    wr(ST, 8'h04);
    wr(EN, 8'h01);
    press(1, 1'b0, 1'b0);
    press(1, 1'b1, 1'b1);
    rd(ST, 8'h00);
    press(1, 1'b0, 1'b0);
    wr(EN, 8'h03);
    cyc(6); // let the pulls settle before the ack
    wr(ST, 8'h05);
    cyc(6);
    rd(ST, 8'h01);
    press(0, 1'b0, 1'b1);
    rd(ST, 8'h09);
    wr(ST, 8'h05);
    rd(ST, 8'h09);
    press(0, 1'b0, 1'b0);
    rd(ST, 8'h01);
    wr(ST, 8'h04);
    press(0, 1'b0, 1'b1);
    brk <= 1'b1;
    wr(ST, 8'h04);
    rd(ST, 8'h08);
    permit <= 1'b1;
    wr(ST, 8'h04);
    rd(ST, 8'h00);
    brk <= 1'b0;
    permit <= 1'b0;
    cyc(2);
    rd(ST, 8'h00);
    wr(ST, 8'h01);
    cyc(6);
    rd(ST, 8'h09);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd(ST, 8'h00);
    rd(PO, 8'h00);
    req(1'b0);
    end_sim();
  end
  // ==========================================================
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : tb_keyboard_pin_interrupt
